//--- tp_polarity_status_collision.sv
`timescale 1ns/100ps
`include "tp_status_defines.svh"

module tp_polarity_status_collision (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic power_down_reset_input,
    input  wire logic rx_pos_excursion,
    input  wire logic rx_neg_excursion,
    input  wire logic rx_carrier,
    input  wire logic rx_data,
    input  wire logic delim_valid,
    input  wire logic delim_pos,
    input  wire logic do_carrier,
    input  wire logic do_data,
    input  wire logic jabber,
    input  wire logic polarity_pin_in,
    output logic      polarity_ok_indicator_out,
    output logic      polarity_ok_indicator_oe,
    output logic      transmit_activity_indicator_n,
    output logic      receive_activity_indicator_n,
    output logic      collision_indicator_n,
    output logic      link_ok_indicator_n,
    output logic      tx_enable,
    output logic      tx_data,
    output logic      di_data,
    output logic      di_active,
    output logic      ci_out,
    output logic      ci_active
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [`PW_BITS-1:0] sat_inc(input logic [`PW_BITS-1:0] v);
        return (v == '1) ? v : v + 1'b1;
    endfunction

    function automatic logic width_ok(input logic [`PW_BITS-1:0] w);
        return (w >= `PW_BITS'(`LBP_MIN_CYCLES)) && (w <= `PW_BITS'(`LBP_MAX_CYCLES));
    endfunction

    logic reset_all;
    assign reset_all = rst || !power_down_reset_input;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tp_status_pkg::link_state_t link_reg;
    tp_status_pkg::pol_state_t  pol_reg;
    logic                       reversed_reg;
    logic                       delim_decided_reg;
    logic                       last_delim_pos_reg;
    logic [`PW_BITS-1:0]        pos_w_reg;
    logic [`PW_BITS-1:0]        neg_w_reg;
    logic                       pos_d_reg;
    logic                       neg_d_reg;
    logic                       beat_first_reg;
    logic                       beat_sign_reg;
    logic [2:0]                 beat_cnt_reg;
    logic                       pol_strap_reg;
    logic [31:0]                lamp_reg;
    logic [31:0]                tx_str_reg;
    logic [31:0]                rx_str_reg;
    logic [31:0]                col_str_reg;
    tp_status_pkg::ci_state_t   ci_reg;
    logic [`CI_BITS-1:0]        ci_cnt_reg;
    logic                       ci_ph_reg;
    logic                       last_src_rx_reg;

    // ----------------------------------------------------------------
    // received-signal classification
    // ----------------------------------------------------------------
    // swap excursions when reversed so classification sees corrected signal
    logic pos_e;
    logic neg_e;
    logic pos_beat;
    logic neg_beat;
    logic beat_ok;
    logic beat_is_pos;
    logic eff_delim_pos;
    logic rx_c;
    assign pos_e = reversed_reg ? rx_neg_excursion : rx_pos_excursion;
    assign neg_e = reversed_reg ? rx_pos_excursion : rx_neg_excursion;
    // a beat ends when its leading excursion ends; a trailing opposite one is allowed
    assign pos_beat = pos_d_reg && !pos_e && width_ok(pos_w_reg) && beat_first_reg;
    assign neg_beat = neg_d_reg && !neg_e && width_ok(neg_w_reg) && !beat_first_reg;
    assign beat_is_pos = pos_beat;
    // in pass only corrected-positive beats count; in failure either does
    assign beat_ok = (link_reg == tp_status_pkg::LINK_FAIL) ? (pos_beat || neg_beat)
                   : pos_beat;
    assign eff_delim_pos = delim_pos ^ reversed_reg;
    assign rx_c = rx_carrier && (link_reg == tp_status_pkg::LINK_PASS);

    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            pos_w_reg      <= '0;
            neg_w_reg      <= '0;
            pos_d_reg      <= 1'b0;
            neg_d_reg      <= 1'b0;
            beat_first_reg <= 1'b1;
        end else begin
            pos_d_reg <= pos_e;
            neg_d_reg <= neg_e;
            pos_w_reg <= pos_e ? sat_inc(pos_w_reg) : '0;
            neg_w_reg <= neg_e ? sat_inc(neg_w_reg) : '0;
            // remember which excursion led the current pulse
            if (pos_e && !neg_d_reg && !pos_d_reg) begin
                beat_first_reg <= 1'b1;
            end else if (neg_e && !pos_d_reg && !neg_d_reg) begin
                beat_first_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // link state and beat counting
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            link_reg      <= tp_status_pkg::LINK_FAIL;
            beat_cnt_reg  <= '0;
            beat_sign_reg <= 1'b1;
        end else if (link_reg == tp_status_pkg::LINK_FAIL) begin
            if (rx_carrier && delim_valid) begin
                link_reg <= tp_status_pkg::LINK_PASS;
            end else if (beat_ok) begin
                if (beat_cnt_reg != 3'd0 && beat_is_pos == beat_sign_reg) begin
                    beat_cnt_reg <= beat_cnt_reg + 3'd1;
                    if (beat_cnt_reg == 3'(`LINK_PULSES_PASS - 1)) begin
                        link_reg <= tp_status_pkg::LINK_PASS;
                    end
                end else begin
                    beat_cnt_reg <= 3'd1;
                end
                beat_sign_reg <= beat_is_pos;
            end
        end else begin
            beat_cnt_reg <= '0;
        end
    end

    // ----------------------------------------------------------------
    // polarity decision
    // ----------------------------------------------------------------
    // our own low drive reads back as ground, so the strap is only seen while released;
    // a strap once seen holds until reset
    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            pol_strap_reg <= 1'b1;
        end else if (!polarity_ok_indicator_oe) begin
            pol_strap_reg <= polarity_pin_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset_all || !pol_strap_reg) begin
            reversed_reg       <= 1'b0;
            pol_reg            <= tp_status_pkg::POL_ARMED;
            delim_decided_reg  <= 1'b0;
            last_delim_pos_reg <= 1'b1;
        end else if (link_reg == tp_status_pkg::LINK_FAIL) begin
            pol_reg           <= tp_status_pkg::POL_ARMED;
            delim_decided_reg <= 1'b0;
            if (beat_ok && beat_cnt_reg == 3'(`LINK_PULSES_PASS - 1)
                && beat_is_pos == beat_sign_reg && !beat_is_pos) begin
                reversed_reg <= !reversed_reg;
            end
        end else if (pol_reg != tp_status_pkg::POL_LOCKED && rx_carrier && delim_valid) begin
            // invalid delimiters never get here
            delim_decided_reg <= 1'b1;
            if (!eff_delim_pos) begin
                reversed_reg <= !reversed_reg;
            end
            if (pol_reg == tp_status_pkg::POL_ONE && eff_delim_pos) begin
                pol_reg <= tp_status_pkg::POL_LOCKED;
            end else begin
                pol_reg <= tp_status_pkg::POL_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // indicators
    // ----------------------------------------------------------------
    logic collision;
    logic in_pass;
    assign in_pass   = (link_reg == tp_status_pkg::LINK_PASS);
    assign collision = in_pass && do_carrier && rx_carrier && !jabber;

    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            lamp_reg    <= 32'(`STRETCH_CYCLES);
            tx_str_reg  <= '0;
            rx_str_reg  <= '0;
            col_str_reg <= '0;
        end else begin
            lamp_reg <= (lamp_reg != '0) ? lamp_reg - 32'd1 : '0;
            if (!in_pass) begin
                tx_str_reg  <= '0;
                rx_str_reg  <= '0;
                col_str_reg <= '0;
            end else begin
                if ((do_carrier && !jabber) || collision) begin
                    tx_str_reg <= 32'(`STRETCH_CYCLES);
                end else if (jabber) begin
                    tx_str_reg <= '0;
                end else if (tx_str_reg != '0) begin
                    tx_str_reg <= tx_str_reg - 32'd1;
                end
                if (rx_carrier) begin
                    rx_str_reg <= 32'(`STRETCH_CYCLES);
                end else if (rx_str_reg != '0) begin
                    rx_str_reg <= rx_str_reg - 32'd1;
                end
                if (collision || jabber) begin
                    col_str_reg <= 32'(`STRETCH_CYCLES);
                end else if (col_str_reg != '0) begin
                    col_str_reg <= col_str_reg - 32'd1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            transmit_activity_indicator_n <= 1'b1;
            receive_activity_indicator_n  <= 1'b1;
            collision_indicator_n         <= 1'b1;
            link_ok_indicator_n           <= 1'b1;
            polarity_ok_indicator_out     <= 1'b0;
            polarity_ok_indicator_oe      <= 1'b0;
        end else begin
            // active low, lamp test overrides transmit, receive and collision but not link
            transmit_activity_indicator_n <= !((lamp_reg != '0) || (tx_str_reg != '0));
            receive_activity_indicator_n  <= !((lamp_reg != '0) || (rx_str_reg != '0));
            collision_indicator_n         <= !((lamp_reg != '0) || (col_str_reg != '0));
            link_ok_indicator_n           <= !in_pass;
            polarity_ok_indicator_out     <= 1'b0;
            polarity_ok_indicator_oe      <= !reversed_reg;
        end
    end

    // ----------------------------------------------------------------
    // received data path through the fifo
    // ----------------------------------------------------------------
    // a small elastic store; it drains at line rate so never fills in practice
    logic rx_fifo_out;
    logic rx_fifo_valid;
    logic rx_fifo_in_ready;
    bit_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) rx_fifo (
        .ref_clk   (ref_clk),
        .rst       (reset_all),
        .in_data   (rx_data ^ reversed_reg),
        .in_valid  (rx_c),
        .in_ready  (rx_fifo_in_ready),
        .out_data  (rx_fifo_out),
        .out_valid (rx_fifo_valid),
        .out_ready (1'b1)
    );

    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            di_data         <= 1'b0;
            di_active       <= 1'b0;
            tx_enable       <= 1'b0;
            tx_data         <= 1'b0;
            last_src_rx_reg <= 1'b0;
        end else begin
            tx_enable <= in_pass && do_carrier && !jabber;
            tx_data   <= do_data;
            if (collision) begin
                last_src_rx_reg <= 1'b1;
                di_data         <= rx_fifo_out;
                di_active       <= rx_fifo_valid;
            end else if (in_pass && rx_carrier && (last_src_rx_reg || !do_carrier)) begin
                di_data   <= rx_fifo_out;
                di_active <= rx_fifo_valid && rx_fifo_in_ready;
            end else if (in_pass && do_carrier) begin
                last_src_rx_reg <= 1'b0;
                di_data         <= do_data; // loopback
                di_active       <= 1'b1;
            end else begin
                last_src_rx_reg <= 1'b0;
                di_data         <= 1'b0;
                di_active       <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // collision presence on CI
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset_all) begin
            ci_reg     <= tp_status_pkg::CI_IDLE;
            ci_cnt_reg <= '0;
            ci_ph_reg  <= 1'b0;
            ci_out     <= 1'b0;
            ci_active  <= 1'b0;
        end else begin
            case (ci_reg)
                tp_status_pkg::CI_IDLE: begin
                    ci_out    <= 1'b0;
                    ci_active <= 1'b0;
                    if (collision || (in_pass && jabber)) begin
                        ci_reg     <= tp_status_pkg::CI_OSC;
                        ci_cnt_reg <= '0;
                    end
                end
                tp_status_pkg::CI_OSC: begin
                    ci_active <= 1'b1;
                    if (ci_cnt_reg == `CI_BITS'(`CI_HALF_CYCLES - 1)) begin
                        ci_cnt_reg <= '0;
                        ci_ph_reg  <= !ci_ph_reg;
                    end else begin
                        ci_cnt_reg <= ci_cnt_reg + 1'b1;
                    end
                    ci_out <= ci_ph_reg;
                    if (!(collision || (in_pass && jabber))) begin
                        ci_reg     <= tp_status_pkg::CI_HOLD;
                        ci_cnt_reg <= '0;
                    end
                end
                tp_status_pkg::CI_HOLD: begin
                    ci_out     <= 1'b1;
                    ci_cnt_reg <= ci_cnt_reg + 1'b1;
                    if (ci_cnt_reg == `CI_BITS'(`CI_HIGH_CYCLES - 1)) begin
                        ci_reg <= tp_status_pkg::CI_DECAY;
                    end
                end
                tp_status_pkg::CI_DECAY: begin
                    // settles at idle well inside the 80 bit-time bound
                    ci_out     <= 1'b0;
                    ci_active  <= 1'b0;
                    ci_reg     <= tp_status_pkg::CI_IDLE;
                    ci_cnt_reg <= '0;
                end
                default: begin
                    ci_reg <= tp_status_pkg::CI_IDLE;
                end
            endcase
        end
    end
endmodule

//--- tp_status_defines.svh
`ifndef TP_STATUS_DEFINES_SVH
`define TP_STATUS_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define STRETCH_MIN_MS     20
`define STRETCH_MAX_MS     62
// 20 ms at 200 MHz, least time rounded up
`define STRETCH_CYCLES     ((`STRETCH_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LBP_MIN_NS         60
`define LBP_MAX_NS         200
`define LBP_MIN_CYCLES     ((`LBP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LBP_MAX_CYCLES     (`LBP_MAX_NS / `CLK_PERIOD_NS)
`define BIT_TIME_NS        100
`define CI_HIGH_BITS       2
`define CI_IDLE_BITS       80
`define CI_HIGH_CYCLES     ((`CI_HIGH_BITS * `BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CI_IDLE_CYCLES     ((`CI_IDLE_BITS * `BIT_TIME_NS) / `CLK_PERIOD_NS)
// 10 MHz square wave: toggle every 50 ns
`define CI_HALF_NS         50
`define CI_HALF_CYCLES     (`CI_HALF_NS / `CLK_PERIOD_NS)
`define LINK_PULSES_PASS   5
`define FIFO_WIDTH         1
`define FIFO_DEPTH         32
`define PW_BITS            8
`define CI_BITS            12

`endif

//--- tp_status_pkg.sv
package tp_status_pkg;
    typedef enum logic [1:0] {LINK_FAIL, LINK_PASS} link_state_t;
    typedef enum logic [1:0] {POL_ARMED, POL_ONE, POL_LOCKED} pol_state_t;
    typedef enum logic [1:0] {CI_IDLE, CI_OSC, CI_HOLD, CI_DECAY} ci_state_t;
endpackage

//--- bit_fifo.sv
`timescale 1ns/100ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

//--- tp_status_assertions.sv
`timescale 1ns/100ps
// ----------
// checker
// ----------
module tp_status_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic power_down_reset_input,
    input wire logic do_carrier,
    input wire logic do_data,
    input wire logic jabber,
    input wire logic polarity_pin_in,
    input wire logic polarity_ok_indicator_out,
    input wire logic polarity_ok_indicator_oe,
    input wire logic link_ok_indicator_n,
    input wire logic tx_enable,
    input wire logic tx_data,
    input wire logic ci_out,
    input wire logic ci_active
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || !power_down_reset_input);
    chk_pol_low:
        assert property (!polarity_ok_indicator_out)
        else $error("polarity pin driven high");
    chk_strap_normal:
        assert property (!polarity_pin_in |-> ##[0:3] polarity_ok_indicator_oe)
        else $error("strap did not force normal polarity");
    chk_fail_no_tx:
        assert property (link_ok_indicator_n && $past(link_ok_indicator_n) |-> !tx_enable)
        else $error("transmit while link failed");
    chk_fail_no_ci:
        assert property (link_ok_indicator_n && $past(link_ok_indicator_n) |-> !ci_active)
        else $error("collision while link failed");
    chk_jabber_no_tx:
        assert property (jabber && $past(jabber) |-> !tx_enable)
        else $error("transmit during jabber");
    chk_jabber_ci_on:
        assert property (!link_ok_indicator_n && jabber && $past(jabber) |-> ##[0:2] ci_active)
        else $error("no collision signal in jabber");
    chk_ci_half_len:
        assert property ($rose(ci_out) |-> ci_out[*8])
        else $error("collision signal half period too short");
    chk_ci_end_hold:
        assert property (!link_ok_indicator_n && ci_active && !jabber && $fell(do_carrier)
            |-> ##3 ci_out[*8] ##[20:60] !ci_out)
        else $error("collision end hold wrong");
    chk_tx_follow:
        assert property (!link_ok_indicator_n && do_carrier && !jabber
            |=> tx_enable && tx_data == $past(do_data))
        else $error("transmit data not forwarded");
    cover property ($rose(ci_out));
    cover property ($fell(link_ok_indicator_n));
    cover property ($fell(polarity_ok_indicator_oe));
endmodule

//--- tp_link_partner.sv
`timescale 1ns/100ps
// ----------
// link partner and station model
// ----------
module tp_link_partner (
    input  wire logic ref_clk,
    output logic      rx_pos_excursion,
    output logic      rx_neg_excursion,
    output logic      rx_carrier,
    output logic      rx_data,
    output logic      delim_valid,
    output logic      delim_pos,
    output logic      do_carrier,
    output logic      do_data
);
    logic idle_tgl = 1'b0;
    // idle lines keep moving so a stale level never passes for data
    always @(posedge ref_clk) idle_tgl <= ~idle_tgl;
    assign rx_data = idle_tgl;
    assign do_data = idle_tgl;
    initial begin
        {rx_pos_excursion, rx_neg_excursion, rx_carrier} = '0;
        {delim_valid, delim_pos, do_carrier} = '0;
    end
    task automatic beat(input logic pos, input int width);
        @(posedge ref_clk);
        rx_pos_excursion <= pos;
        rx_neg_excursion <= ~pos;
        repeat (width) @(posedge ref_clk);
        rx_pos_excursion <= 1'b0;
        rx_neg_excursion <= 1'b0;
        repeat (20) @(posedge ref_clk);
    endtask
    task automatic carrier(input logic on);
        @(posedge ref_clk) rx_carrier <= on;
    endtask
    task automatic dte(input logic on);
        @(posedge ref_clk) do_carrier <= on;
    endtask
    task automatic packet(input logic valid, input logic pos);
        carrier(1'b1);
        repeat (30) @(posedge ref_clk);
        delim_valid <= valid;
        delim_pos   <= pos;
        @(posedge ref_clk);
        delim_valid <= 1'b0;
        rx_carrier  <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask
endmodule

//--- tp_polarity_status_collision_test.sv
`timescale 1ns/100ps
// ----------
// bench
// ----------
module tp_polarity_status_collision_test;
    logic ref_clk                = 1'b0;
    logic rst                    = 1'b1;
    logic power_down_reset_input = 1'b1;
    logic jabber                 = 1'b0;
    logic strap_gnd              = 1'b0;
    logic rx_pos_excursion, rx_neg_excursion, rx_carrier, rx_data, delim_valid, delim_pos;
    logic do_carrier, do_data, polarity_ok_indicator_out, polarity_ok_indicator_oe;
    logic transmit_activity_indicator_n, receive_activity_indicator_n, collision_indicator_n;
    logic link_ok_indicator_n, tx_enable, tx_data, di_data, di_active, ci_out, ci_active;
    logic ci_seen;
    wire  polarity_pin_in;
    int   fail_count      = 0;
    int   samples_checked = 0;
    // pin pulled up unless driven low by the block or grounded on the board
    assign polarity_pin_in = !strap_gnd && !(polarity_ok_indicator_oe && !polarity_ok_indicator_out);
    tp_polarity_status_collision tp_polarity_status_collision_inst (
        .ref_clk(ref_clk), .rst(rst), .power_down_reset_input(power_down_reset_input),
        .rx_pos_excursion(rx_pos_excursion), .rx_neg_excursion(rx_neg_excursion),
        .rx_carrier(rx_carrier), .rx_data(rx_data), .delim_valid(delim_valid),
        .delim_pos(delim_pos), .do_carrier(do_carrier), .do_data(do_data), .jabber(jabber),
        .polarity_pin_in(polarity_pin_in),
        .polarity_ok_indicator_out(polarity_ok_indicator_out),
        .polarity_ok_indicator_oe(polarity_ok_indicator_oe),
        .transmit_activity_indicator_n(transmit_activity_indicator_n),
        .receive_activity_indicator_n(receive_activity_indicator_n),
        .collision_indicator_n(collision_indicator_n),
        .link_ok_indicator_n(link_ok_indicator_n), .tx_enable(tx_enable), .tx_data(tx_data),
        .di_data(di_data), .di_active(di_active), .ci_out(ci_out), .ci_active(ci_active)
    );
    tp_link_partner tp_link_partner_inst (
        .ref_clk(ref_clk), .rx_pos_excursion(rx_pos_excursion),
        .rx_neg_excursion(rx_neg_excursion), .rx_carrier(rx_carrier), .rx_data(rx_data),
        .delim_valid(delim_valid), .delim_pos(delim_pos), .do_carrier(do_carrier),
        .do_data(do_data)
    );
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %b seen %b", what, exp, seen);
            fail_count++;
        end
    endtask
    // n rising edges, then look at settled outputs on the falling edge
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wait_link(input logic exp);
        for (int i = 0; i < 40 && link_ok_indicator_n !== exp; i++) @(negedge ref_clk);
        if (link_ok_indicator_n !== exp) begin
            check("link wait", link_ok_indicator_n, exp);
            conclude();
        end
    endtask
    task automatic t_fail();
        tp_link_partner_inst.dte(1'b1);
        settle(4);
        check("xmt lamp", transmit_activity_indicator_n, 1'b0);
        check("rcv lamp", receive_activity_indicator_n, 1'b0);
        check("col lamp", collision_indicator_n, 1'b0);
        check("tx in fail", tx_enable, 1'b0);
        check("ci in fail", ci_active, 1'b0);
        tp_link_partner_inst.dte(1'b0);
    endtask
    task automatic t_beats();
        repeat (4) tp_link_partner_inst.beat(1'b1, 20);
        tp_link_partner_inst.beat(1'b0, 20);
        tp_link_partner_inst.beat(1'b1, 8);
        repeat (4) tp_link_partner_inst.beat(1'b1, 20);
        settle(1);
        check("link early", link_ok_indicator_n, 1'b1);
        tp_link_partner_inst.beat(1'b1, 20);
        wait_link(1'b0);
        check("normal after beats", polarity_ok_indicator_oe, 1'b1);
    endtask
    task automatic t_pol();
        tp_link_partner_inst.packet(1'b0, 1'b0);
        settle(1);
        check("bad delimiter", polarity_ok_indicator_oe, 1'b1);
        tp_link_partner_inst.packet(1'b1, 1'b0);
        settle(1);
        check("first delimiter", polarity_ok_indicator_oe, 1'b0);
        repeat (2) tp_link_partner_inst.packet(1'b1, 1'b0);
        tp_link_partner_inst.packet(1'b1, 1'b1);
        settle(1);
        check("locked", polarity_ok_indicator_oe, 1'b0);
    endtask
    task automatic t_coll();
        tp_link_partner_inst.carrier(1'b1);
        tp_link_partner_inst.dte(1'b1);
        settle(6);
        ci_seen = ci_out;
        check("ci active", ci_active, 1'b1);
        check("di inverted rx", di_data, ~rx_data);
        settle(10);
        check("ci toggles", ci_out, ~ci_seen);
        tp_link_partner_inst.dte(1'b0);
        settle(20);
        check("ci hold", ci_out, 1'b1);
        check("di after", di_data, ~rx_data);
        check("di active", di_active, 1'b1);
        settle(40);
        check("ci idle", ci_out, 1'b0);
        tp_link_partner_inst.carrier(1'b0);
    endtask
    task automatic t_tx();
        tp_link_partner_inst.dte(1'b1);
        settle(3);
        check("tx on", tx_enable, 1'b1);
        @(posedge ref_clk) jabber <= 1'b1;
        settle(3);
        check("tx jabber", tx_enable, 1'b0);
        check("ci jabber", ci_active, 1'b1);
        @(posedge ref_clk) jabber <= 1'b0;
        settle(60);
        tp_link_partner_inst.dte(1'b0);
        @(posedge ref_clk) strap_gnd <= 1'b1;
        settle(4);
        check("strap", polarity_ok_indicator_oe, 1'b1);
        @(posedge ref_clk) strap_gnd <= 1'b0;
    endtask
    task automatic t_pdr();
        @(posedge ref_clk) power_down_reset_input <= 1'b0;
        settle(3);
        check("link lost", link_ok_indicator_n, 1'b1);
        @(posedge ref_clk) power_down_reset_input <= 1'b1;
        repeat (5) tp_link_partner_inst.beat(1'b0, 20);
        wait_link(1'b0);
        check("reversed by beats", polarity_ok_indicator_oe, 1'b0);
        tp_link_partner_inst.packet(1'b1, 1'b1);
        settle(1);
        check("rearmed", polarity_ok_indicator_oe, 1'b1);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        check("link in reset", link_ok_indicator_n, 1'b1);
        check("col in reset", collision_indicator_n, 1'b1);
        @(posedge ref_clk) rst <= 1'b0;
        t_fail();
        t_beats();
        t_pol();
        t_coll();
        t_tx();
        t_pdr();
        conclude();
    end
endmodule
bind tp_polarity_status_collision tp_status_assertions tp_status_assertions_inst (.*);
